// File: verilog/chp_pins.sv
/*
 Configuration-time control pin logic: hold pin, chip selects and read
 strobe with data-bus status drive.
 Assumes all pins come from outside the clock domain and the core
 supplies power-good, clear-done, config-done and status levels.
 The pad cells outside turn the enable outputs into open-drain or
 tristate drivers; the pull-up on the hold pin sits outside as well.
*/
`default_nettype none
module chp_pins
(
   input wire logic clk,
   input wire logic rst_b,
   input wire chp_pkg::chp_mode_t cfg_mode,
   input wire logic power_good,
   input wire logic clear_done,
   input wire logic config_done,
   input wire logic host_cpu_port_used,
   input wire logic [4:0] cfg_status,
   input wire logic cfg_hold_n_in,
   output logic cfg_hold_n_out,
   output logic cfg_hold_n_oe,
   input wire logic chip_select_low_n,
   input wire logic chip_select_high,
   input wire logic rd_n,
   input wire logic wr_n,
   output logic [4:0] data_hi_out,
   output logic data_hi_oe,
   output logic cfg_start,
   output logic cfg_active,
   output logic hold_user_io,
   output logic select_user_io,
   output logic selected,
   output logic write_strobe,
   output logic host_transfer_strobe
);
   import chp_pkg::*;

   // Whole state of the block; one copy is the next value
   typedef struct packed {
      logic [1:0] hold_s;
      logic [1:0] csl_s;
      logic [1:0] csh_s;
      logic [1:0] rd_s;
      logic [1:0] wr_s;
      chp_state_t st;
      logic start;
      logic [CHP_STATUS_W-1:0] dout;
      logic doe;
   } chp_regs_t;

   chp_regs_t r_q;
   chp_regs_t r_d;
   logic sel_mode;
   logic sel;
   logic rd_act;
   logic wr_act;

   // Pins pass two flip-flops; logic reads only the second stage so a
   // metastable first stage never reaches a decision
   assign sel_mode = (cfg_mode == CHP_MODE_ASYNC_PERIPH) || (cfg_mode == CHP_MODE_SLAVE_PAR)
                     || (cfg_mode == CHP_MODE_HOST_CPU); // RQ4
   assign sel = sel_mode && !r_q.csl_s[1] && r_q.csh_s[1]; // RQ5
   // A write beats a read in the same cycle, so a host slip never drives the bus
   assign wr_act = sel && !r_q.wr_s[1];
   assign rd_act = sel && !r_q.rd_s[1] && !wr_act; // RQ7

   // Next-state logic for the whole block
   always_comb
   begin
      // Every field holds unless an assignment below moves it
      r_d = r_q;
      r_d.hold_s = {r_q.hold_s[0], cfg_hold_n_in};
      r_d.csl_s = {r_q.csl_s[0], chip_select_low_n};
      r_d.csh_s = {r_q.csh_s[0], chip_select_high};
      r_d.rd_s = {r_q.rd_s[0], rd_n};
      r_d.wr_s = {r_q.wr_s[0], wr_n};
      r_d.start = 1'b0;
      case (r_q.st)
         CHP_ST_CLEAR:
         begin
            // Both core levels are needed; either alone keeps the pin pulled
            if (power_good && clear_done)
            begin
               r_d.st = CHP_ST_WAIT; // RQ11
            end
         end
         CHP_ST_WAIT:
         begin
            // An outside party holding the pin low keeps us here
            if (r_q.hold_s[1])
            begin
               r_d.st = CHP_ST_CONFIG; // RQ2 RQ11
               r_d.start = 1'b1;
            end
         end
         CHP_ST_CONFIG:
         begin
            // Completion arrives as a level from the core
            if (config_done)
            begin
               r_d.st = CHP_ST_USER; // RQ3
            end
         end
         CHP_ST_USER:
         begin
            // Only a reset leaves user mode
            r_d.st = CHP_ST_USER;
         end
         default:
         begin
            r_d.st = CHP_ST_CLEAR;
         end
      endcase
      // Status is driven only during async peripheral reads in configuration
      // Registered so the data pins never follow a glitch on the select path
      r_d.doe = (r_q.st == CHP_ST_CONFIG) && (cfg_mode == CHP_MODE_ASYNC_PERIPH)
                && rd_act; // RQ6
      r_d.dout = cfg_status; // RQ9
   end

   // State register; reset leaves the hold pin pulled low
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         // Synchronisers start at the idle pin levels so no false select follows reset
         r_q <= '{hold_s: 2'h0,
                  csl_s: 2'h3,
                  csh_s: 2'h0,
                  rd_s: 2'h3,
                  wr_s: 2'h3,
                  st: chp_state_t'(CHP_ST_RESET),
                  start: 1'b0,
                  dout: CHP_STATUS_RESET,
                  doe: 1'b0};
      end
      else
      begin
         r_q <= r_d;
      end
   end

   // Open drain: only ever pull low, and only while clearing
   assign cfg_hold_n_out = 1'b0;
   assign cfg_hold_n_oe = (r_q.st == CHP_ST_CLEAR); // RQ1
   // Sequence start pulse and levels handed to the core
   assign cfg_start = r_q.start;
   assign cfg_active = (r_q.st == CHP_ST_CONFIG);
   assign hold_user_io = (r_q.st == CHP_ST_USER); // RQ3
   // Selects stay in service after configuration for the host CPU port
   assign select_user_io = (r_q.st == CHP_ST_USER) && !host_cpu_port_used; // RQ10
   assign selected = sel && !select_user_io;
   assign write_strobe = wr_act && !select_user_io; // RQ7
   // The read pin doubles as the host CPU port strobe
   assign host_transfer_strobe = (cfg_mode == CHP_MODE_HOST_CPU || host_cpu_port_used)
                                 && sel && !r_q.rd_s[1] && !select_user_io; // RQ8
   // Data pins come straight from flip-flops
   assign data_hi_out = r_q.dout;
   assign data_hi_oe = r_q.doe;

   // Checks; all stand idle while reset is low
   hold_low_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ1
      (r_q.st == CHP_ST_CLEAR) |-> cfg_hold_n_oe && !cfg_hold_n_out)
      else $error("hold pin not pulled while clearing");
   wait_held_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ2
      (r_q.st == CHP_ST_WAIT && !r_q.hold_s[1]) |=> (r_q.st == CHP_ST_WAIT))
      else $error("left wait while hold pin low");
   user_release_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ3
      (r_q.st == CHP_ST_USER) |-> !cfg_hold_n_oe && hold_user_io)
      else $error("hold pin not released after config");
   mode_gate_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ4
      (cfg_mode == CHP_MODE_MASTER || cfg_mode == CHP_MODE_SLAVE_SER) |-> !selected)
      else $error("select honoured in wrong mode");
   select_pair_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ5
      selected |-> !r_q.csl_s[1] && r_q.csh_s[1])
      else $error("selected without both selects");
   status_drive_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ6
      ($past(r_q.st) == CHP_ST_CONFIG && $past(rd_act)
       && $past(cfg_mode) == CHP_MODE_ASYNC_PERIPH) |-> data_hi_oe)
      else $error("status not driven on read");
   write_wins_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ7
      (sel && !r_q.wr_s[1]) |-> !rd_act ##1 !data_hi_oe)
      else $error("read acted during write");
   strobe_map_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ8
      (cfg_mode == CHP_MODE_HOST_CPU && sel && !r_q.rd_s[1] && !select_user_io)
      |-> host_transfer_strobe)
      else $error("read pin not used as transfer strobe");
   status_value_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ9
      data_hi_oe |-> data_hi_out == $past(cfg_status))
      else $error("status value mismatch");
   sel_user_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ10
      (r_q.st == CHP_ST_USER && !host_cpu_port_used) |-> !selected)
      else $error("selects kept after config without host port");
   start_first_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ11
      (r_q.st == CHP_ST_WAIT && r_q.hold_s[1]) |=> cfg_start && cfg_active)
      else $error("config did not start on first high sample");
   // Further checks on the sequence, the selects and the status drive
   clear_wait_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ11
      (r_q.st == CHP_ST_CLEAR && !(power_good && clear_done)) |=> cfg_hold_n_oe)
      else $error("hold pin released before clearing finished");
   start_pulse_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ11
      cfg_start |=> !cfg_start)
      else $error("start pulse longer than one cycle");
   user_stays_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ3
      hold_user_io |=> hold_user_io)
      else $error("left user mode without reset");
   sel_kept_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ10
      (hold_user_io && host_cpu_port_used) |-> !select_user_io)
      else $error("selects released although host port kept");
   status_mode_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ6
      data_hi_oe |-> $past(cfg_mode) == CHP_MODE_ASYNC_PERIPH)
      else $error("status driven outside async peripheral mode");
   // Main scenarios
   cfg_run_c: cover property (@(posedge clk) disable iff (!rst_b) cfg_start);
   status_rd_c: cover property (@(posedge clk) disable iff (!rst_b) data_hi_oe);
   user_c: cover property (@(posedge clk) disable iff (!rst_b) hold_user_io);
   write_win_c: cover property (@(posedge clk) disable iff (!rst_b)
      sel && !r_q.wr_s[1] && !r_q.rd_s[1]);
   host_keep_c: cover property (@(posedge clk) disable iff (!rst_b)
      hold_user_io && host_cpu_port_used && selected);
endmodule : chp_pins
`default_nettype wire

// File: common/chp_pkg.sv
/*
 Constants, modes and state encodings shared by the configuration
 host-port pin block.
 Assumes a single 50 MHz clock and an active-low asynchronous reset.
*/
// Summary of operation
// [RQ1] Drive the hold pin low while power settles and configuration memory clears.
// [RQ2] An external low on the hold pin keeps the device waiting, no configuration.
// [RQ3] After configuration the hold pin becomes ordinary user I/O.
// [RQ4] Chip selects count only in async peripheral, slave parallel, host CPU modes.
// [RQ5] Selected only when the low select is low and the high select high.
// [RQ6] In async peripheral mode a low read strobe turns D[7:3] into status outputs.
// [RQ7] Host must not assert read and write together; write wins if it does; host_transfer_strobe still fires with write_strobe.
// [RQ8] With the host CPU port in use, the read pin is its transfer strobe.
// [RQ9] Status reads high for ready and low for busy.
// [RQ10] After configuration selects become user I/O unless host CPU port is used.
// [RQ11] Release hold only after power and clearing finish; start on first high sample.
`default_nettype none
package chp_pkg;
   // Configuration modes seen by the pin logic
   typedef enum logic [2:0] {
      CHP_MODE_MASTER = 3'h0,
      CHP_MODE_ASYNC_PERIPH = 3'h1,
      CHP_MODE_SLAVE_PAR = 3'h2,
      CHP_MODE_HOST_CPU = 3'h3,
      CHP_MODE_SLAVE_SER = 3'h4
   } chp_mode_t;

   // Sequence of the configuration phase, Gray coded along the usual path
   typedef enum logic [1:0] {
      CHP_ST_CLEAR = 2'h0,
      CHP_ST_WAIT = 2'h1,
      CHP_ST_CONFIG = 2'h3,
      CHP_ST_USER = 2'h2
   } chp_state_t;

   localparam logic [1:0] CHP_ST_RESET = 2'h0;
   localparam int CHP_STATUS_LSB = 3;
   localparam int CHP_STATUS_W = 5;
   localparam logic [4:0] CHP_STATUS_RESET = 5'h00;
endpackage : chp_pkg
`default_nettype wire

// File: tb/chp_host_model.sv
/* Host side of the hold pin: open-drain wire with pull-up.
 Assumes the device enable pulls the pin low. */
`default_nettype none
module chp_host_model
(
   input wire logic dev_oe,
   input wire logic host_hold,
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // Any party pulling low wins; pull-up otherwise
   assign pin = (dev_oe || host_hold) ? 1'b0 : 1'b1;
endmodule : chp_host_model
`default_nettype wire

// File: tb/chp_pins_tb.sv
/* Self-checking bench for the configuration pin block.
 Assumes chp_pkg and the host model are compiled first. */
`default_nettype none
module chp_pins_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import chp_pkg::*;
   logic clk, rst_b = 0, pg = 0, cd = 0, dn = 0, hu = 0, hh = 0, pin;
   logic cs0 = 1, cs1 = 0, rd_n = 1, wr_n = 1, ho, hoe, oe, start, act;
   logic hio, sio, sel, ws, hts;
   chp_mode_t md = CHP_MODE_MASTER;
   logic [4:0] st = 5'h15, dho;
   int n_errors = 0;
   int checked = 0;
   chp_pins i_chp_pins (.clk(clk), .rst_b(rst_b), .cfg_mode(md), .power_good(pg),
      .clear_done(cd), .config_done(dn), .host_cpu_port_used(hu), .cfg_status(st),
      .cfg_hold_n_in(pin), .cfg_hold_n_out(ho), .cfg_hold_n_oe(hoe),
      .chip_select_low_n(cs0), .chip_select_high(cs1), .rd_n(rd_n), .wr_n(wr_n),
      .data_hi_out(dho), .data_hi_oe(oe), .cfg_start(start), .cfg_active(act),
      .hold_user_io(hio), .select_user_io(sio), .selected(sel), .write_strobe(ws),
      .host_transfer_strobe(hts));
   chp_host_model i_chp_host_model (.dev_oe(hoe), .host_hold(hh), .pin(pin));
   // 50 MHz clock
   initial
   begin
      clk = 0;
      forever #10 clk = ~clk;
   end
   task automatic final_report;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   // Inputs move 2 ns after the edge, so outputs are settled there too
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : cyc
   // Clearing needs both core levels; the host then holds the pin past clearing
   task automatic t_start;
      int i;
      chk(8'(hoe), 8'h01);
      chk(8'(ho), 8'h00);
      hh = 1;
      pg = 1;
      cyc(4);
      chk(8'(hoe), 8'h01);
      cd = 1;
      cyc(6);
      chk(8'(hoe), 8'h00);
      chk(8'(act), 8'h00);
      hh = 0;
      // Two sync stages and the state register lie between pin and start
      for (i = 0; i < 6 && start !== 1'b1; i++)
      begin
         cyc(1);
      end
      chk(8'(i), 8'h03);
      chk(8'(start), 8'h01);
      chk(8'(act), 8'h01);
      cyc(1);
      chk(8'(start), 8'h00);
   endtask : t_start
   // Status read, status follow, write priority, then a half-valid select
   task automatic t_read;
      md = CHP_MODE_ASYNC_PERIPH;
      cs0 = 0;
      cs1 = 1;
      rd_n = 0;
      cyc(4);
      chk(8'(sel), 8'h01);
      chk(8'(oe), 8'h01);
      chk(8'(dho), 8'h15);
      st = 5'h0A;
      cyc(1);
      chk(8'(dho), 8'h0A);
      wr_n = 0;
      cyc(4);
      chk(8'(ws), 8'h01);
      chk(8'(oe), 8'h00);
      wr_n = 1;
      cs1 = 0;
      cyc(4);
      chk(8'(sel), 8'h00);
      chk(8'(oe), 8'h00);
   endtask : t_read
   // Every mode with a valid select and the read pin low
   task automatic t_modes;
      cs1 = 1;
      for (int m = 0; m < 5; m++)
      begin
         md = chp_mode_t'(m);
         cyc(4);
         chk(8'(sel), 8'(m inside {1, 2, 3}));
         chk(8'(oe), 8'(m == 1));
         chk(8'(hts), 8'(m == 3));
      end
   endtask : t_modes
   // After configuration, without and then with the host port kept
   task automatic t_user;
      md = CHP_MODE_HOST_CPU;
      dn = 1;
      cyc(4);
      chk(8'(hio), 8'h01);
      chk(8'(hoe), 8'h00);
      chk(8'(sio), 8'h01);
      chk(8'(sel), 8'h00);
      chk(8'(hts), 8'h00);
      rst_b = 0;
      hu = 1;
      cyc(6);
      chk(8'(hoe), 8'h01);
      chk(8'(start), 8'h00);
      rst_b = 1;
      cyc(12);
      chk(8'(hio), 8'h01);
      chk(8'(sio), 8'h00);
      chk(8'(sel), 8'h01);
      chk(8'(hts), 8'h01);
   endtask : t_user
   initial
   begin
      cyc(6);
      rst_b = 1;
      t_start();
      t_read();
      t_modes();
      t_user();
      final_report();
   end
   // Tests need well under 200 cycles
   initial
   begin
      #20000;
      n_errors++;
      final_report();
   end
endmodule : chp_pins_tb
`default_nettype wire
